/* core/ppd_port.sv */
// Purpose: eight-pin port with direction, drive and pull configuration
// Assumes: pin inputs synchronous to pclk; APB4 slave, no wait states
// Notes:   pad controls are registered one cycle after the register
//
// Chosen here: the APB register port.
`include "ppd_map.svh"
`default_nettype none
module ppd_port #(
   parameter int ADDR_W = 20,
   parameter int PINS = 8
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // alternate function levels from peripherals
   input wire logic [PINS-1:0] alt_level,
   // pads
   input wire logic [PINS-1:0] pin_i,
   output logic [PINS-1:0] pin_o,
   output logic [PINS-1:0] pin_oe_n,
   output logic [PINS-1:0] pull_up_en,
   output logic [PINS-1:0] pull_dn_en
);
   import ppd_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   ppd_pkg::ppd_state_t s_q;
   ppd_pkg::ppd_state_t s_d;
   logic [`PPD_IDX_W-1:0] idx;
   logic setup;
   logic wr;
   logic [PINS-1:0] alt_sel;
   logic [PINS-1:0] level;
   logic [PINS-1:0] drv;
   logic [PINS-1:0] pu;
   logic [PINS-1:0] pd;

   assign idx = paddr[ADDR_W-1:2];
   assign setup = psel && !penable;
   assign wr = psel && penable && pwrite && s_q.pready;

   // ---------------------------------------------------------------
   // per-pin decode
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < PINS; g++)
      begin : g_pin
         assign alt_sel[g] = s_q.mode[g] || s_q.mode[g + `PPD_HI_OFS];
         // output shows data bit or peripheral level
         assign level[g] = (g >= `PPD_ALT_FIRST && alt_sel[g]) ?
            alt_level[g] : s_q.data[g];
         ppd_pin_cell #(
            .HAS_ALT(g >= `PPD_ALT_FIRST)
         ) u_cell (
            .dir(s_q.dir[g]),
            .set_hi(s_q.ctrl[g + `PPD_HI_OFS]),
            .set_lo(s_q.ctrl[g]),
            .alt_sel(alt_sel[g]),
            .level(level[g]),
            .drive(drv[g]),
            .pull_up(pu[g]),
            .pull_dn(pd[g])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;
      s_d.pready = setup;
      s_d.pslverr = 1'b0;
      if (setup)
      begin
         s_d.prdata = `PPD_RST_RDATA;
         if (idx == `PPD_IDX_DATA)
         begin
            // input pins read the pad, output pins the latch
            s_d.prdata[`PPD_LO_BYTE] =
               (s_q.dir & pin_i) | (~s_q.dir & s_q.data);
         end
         else if (idx == `PPD_IDX_DIR)
         begin
            s_d.prdata[`PPD_LO_BYTE] = s_q.dir;
         end
         else if (idx == `PPD_IDX_CTRL_LO)
         begin
            s_d.prdata[`PPD_WORD] = s_q.ctrl;
         end
         else if (idx == `PPD_IDX_CTRL_HI)
         begin
            s_d.prdata[`PPD_LO_BYTE] = s_q.ctrl[`PPD_HI_BYTE];
         end
         else if (idx == `PPD_IDX_MODE_LO)
         begin
            s_d.prdata[`PPD_WORD] = s_q.mode;
         end
         else if (idx == `PPD_IDX_MODE_HI)
         begin
            s_d.prdata[`PPD_LO_BYTE] = s_q.mode[`PPD_HI_BYTE];
         end
         else
         begin
            s_d.pslverr = 1'b1;
         end
      end
      if (wr)
      begin
         if (idx == `PPD_IDX_DATA)
         begin
            if (pstrb[0])
               s_d.data = pwdata[`PPD_LO_BYTE];
         end
         else if (idx == `PPD_IDX_DIR)
         begin
            if (pstrb[0])
               s_d.dir = pwdata[`PPD_LO_BYTE];
         end
         else if (idx == `PPD_IDX_CTRL_LO)
         begin
            // word access covers both bytes, lanes pick which
            if (pstrb[0])
               s_d.ctrl[`PPD_LO_BYTE] = pwdata[`PPD_LO_BYTE];
            if (pstrb[1])
               s_d.ctrl[`PPD_HI_BYTE] = pwdata[`PPD_HI_BYTE];
         end
         else if (idx == `PPD_IDX_CTRL_HI)
         begin
            if (pstrb[0])
               s_d.ctrl[`PPD_HI_BYTE] = pwdata[`PPD_LO_BYTE];
         end
         else if (idx == `PPD_IDX_MODE_LO)
         begin
            if (pstrb[0])
               s_d.mode[`PPD_LO_BYTE] = pwdata[`PPD_LO_BYTE];
            if (pstrb[1])
               s_d.mode[`PPD_HI_BYTE] = pwdata[`PPD_HI_BYTE];
         end
         else if (idx == `PPD_IDX_MODE_HI)
         begin
            if (pstrb[0])
               s_d.mode[`PPD_HI_BYTE] = pwdata[`PPD_LO_BYTE];
         end
      end
      // pad controls follow the registers one cycle later
      s_d.pin_o = level;
      s_d.pin_oe_n = ~drv;
      s_d.pull_up = pu;
      s_d.pull_dn = pd;
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q.data <= `PPD_RST_DATA;
         s_q.dir <= `PPD_RST_DIR;
         s_q.ctrl <= `PPD_RST_CTRL;
         s_q.mode <= `PPD_RST_MODE;
         s_q.prdata <= `PPD_RST_RDATA;
         s_q.pready <= 1'b0;
         s_q.pslverr <= 1'b0;
         s_q.pin_o <= `PPD_RST_DATA;
         s_q.pin_oe_n <= ~`PPD_RST_DATA;
         s_q.pull_up <= `PPD_RST_DATA;
         s_q.pull_dn <= `PPD_RST_DATA;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign pin_o = s_q.pin_o;
   assign pin_oe_n = s_q.pin_oe_n;
   assign pull_up_en = s_q.pull_up;
   assign pull_dn_en = s_q.pull_dn;
endmodule : ppd_port
`default_nettype wire

/* core/ppd_map.svh */
// Purpose: register map, reset values and field positions of the port
//          pin direction and drive configuration block
// Assumes: APB with 32-bit data; one register index per aligned word
// Notes:   byte address of a register is four times its index
`ifndef PPD_MAP_SVH
`define PPD_MAP_SVH

// ------------------------------------------------------------------
// register indices (byte address = index * 4)
// ------------------------------------------------------------------
`define PPD_IDX_W 18
`define PPD_IDX_DATA 18'h0_f228
`define PPD_IDX_DIR 18'h0_f229
`define PPD_IDX_CTRL_LO 18'h0_f22a
`define PPD_IDX_CTRL_HI 18'h0_f22b
`define PPD_IDX_MODE_LO 18'h0_f22c
`define PPD_IDX_MODE_HI 18'h0_f22d

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define PPD_RST_DATA 8'h00
`define PPD_RST_DIR 8'h00
`define PPD_RST_CTRL 16'h0000
`define PPD_RST_MODE 16'h0000
`define PPD_RST_RDATA 32'h0000_0000

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define PPD_LO_BYTE 7:0
`define PPD_HI_BYTE 15:8
`define PPD_WORD 15:0
`define PPD_HI_OFS 8
`define PPD_ALT_FIRST 4
`define PPD_DIR_OUT 1'b0

`endif

/* core/ppd_pkg.sv */
// Purpose: types shared by the port configuration block
// Assumes: eight pins
// Notes:   all state of the top lives in one packed struct
`default_nettype none
package ppd_pkg;
   typedef struct packed {
      logic [7:0] data;
      logic [7:0] dir;
      logic [15:0] ctrl;
      logic [15:0] mode;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [7:0] pin_o;
      logic [7:0] pin_oe_n;
      logic [7:0] pull_up;
      logic [7:0] pull_dn;
   } ppd_state_t;
endpackage : ppd_pkg
`default_nettype wire

/* core/ppd_pin_cell.sv */
// Purpose: decode of one pin's direction and two-bit drive setting
// Assumes: level is the value the pin should carry when driven
// Notes:   purely combinational; the top registers its results
`include "ppd_map.svh"
`default_nettype none
module ppd_pin_cell #(
   parameter bit HAS_ALT = 1'b0
) (
   // configuration
   input wire logic dir,
   input wire logic set_hi,
   input wire logic set_lo,
   input wire logic alt_sel,
   input wire logic level,
   // pad control
   output logic drive,
   output logic pull_up,
   output logic pull_dn
);
   always_comb
   begin
      drive = 1'b0;
      pull_up = 1'b0;
      pull_dn = 1'b0;
      if (dir == `PPD_DIR_OUT)
      begin
         if (HAS_ALT && alt_sel)
         begin
            // alternate function: x0 n-open drain, x1 cmos
            if (set_lo)
               drive = 1'b1;
            else
               drive = !level;
         end
         else
         begin
            case ({set_hi, set_lo})
               2'b01: drive = level;
               2'b10: drive = !level;
               2'b11: drive = 1'b1;
               default: drive = 1'b0;
            endcase
         end
      end
      else
      begin
         pull_dn = !set_hi && set_lo;
         pull_up = set_hi && !set_lo;
      end
   end
endmodule : ppd_pin_cell
`default_nettype wire

/* bench/ppd_sva.sv */
// Purpose: bus and pad checks on the port block
// Assumes: sees the top ports only
// Notes: bound to every instance of the top below
`include "ppd_map.svh"
`default_nettype none
module ppd_sva #(
   parameter int ADDR_W = 20,
   parameter int PINS = 8
) (
   // clock and bus
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // pads
   input wire logic [PINS-1:0] pin_oe_n,
   input wire logic [PINS-1:0] pull_up_en,
   input wire logic [PINS-1:0] pull_dn_en
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   chk_ready_gap:
      assert property (psel && !penable |=> pready)
      else $error("late ready");
   chk_ready_pulse:
      assert property (pready |=> !pready)
      else $error("long ready");
   chk_err_zero:
      assert property (pslverr |-> pready && prdata == '0)
      else $error("error data");
   chk_pull_excl:
      assert property ((pull_up_en & pull_dn_en) == '0)
      else $error("both pulls");
   chk_pull_out:
      assert property (((pull_up_en | pull_dn_en) & ~pin_oe_n) == '0)
      else $error("pull on driven pad");
   chk_dir_input:
      assert property (psel && penable && pwrite && pready && pstrb[0]
         && paddr[ADDR_W-1:2] == `PPD_IDX_DIR && pwdata[7:0] == 8'hff
         |-> ##2 pin_oe_n == '1)
      else $error("dir not applied");
   chk_reset_idle:
      assert property ($rose(presetn) |-> pin_oe_n == '1 && !pready)
      else $error("reset state");
   chk_map_err:
      assert property (psel && penable && pready |-> pslverr
         == !(paddr[ADDR_W-1:2] inside {[`PPD_IDX_DATA:`PPD_IDX_MODE_HI]}))
      else $error("error flag");
endmodule : ppd_sva
bind ppd_port ppd_sva #(.ADDR_W(ADDR_W), .PINS(PINS)) u_sva (.pclk,
   .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
   .pready, .pslverr, .pin_oe_n, .pull_up_en, .pull_dn_en);
`default_nettype wire

/* bench/ppd_board.sv */
// Purpose: board circuitry on the pads
// Assumes: board drives a pin only where ext_en is set
// Notes: a pin nobody holds wanders every cycle
`default_nettype none
module ppd_board (
   // pads and board drive
   input wire logic pclk,
   input wire logic [7:0] pin_o,
   input wire logic [7:0] pin_oe_n,
   input wire logic [7:0] pull_up_en,
   input wire logic [7:0] pull_dn_en,
   input wire logic [7:0] ext_lvl,
   input wire logic [7:0] ext_en,
   output logic [7:0] pin_i
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] flt_q = 8'h00;
   always @(posedge pclk)
      flt_q <= ~pin_i;
   always_comb
      for (int n = 0; n < 8; n++)
         if (!pin_oe_n[n])
            pin_i[n] = pin_o[n];
         else if (ext_en[n])
            pin_i[n] = ext_lvl[n];
         else if (pull_up_en[n] | pull_dn_en[n])
            pin_i[n] = pull_up_en[n];
         else
            pin_i[n] = flt_q[n];
endmodule : ppd_board
`default_nettype wire

/* bench/tb_top.sv */
// Purpose: self-checking bench for the port block
// Assumes: slave answers by pready
// Notes: pads are looked at mid-cycle after settle, except the oe_n check in t_reset, taken at a rising edge
`include "ppd_map.svh"
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [19:0] paddr = 20'h0_0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'h0;
   logic [7:0] alt_level = 8'h00;
   logic [7:0] ext_lvl = 8'h00;
   logic [7:0] ext_en = 8'h00;
   logic [31:0] prdata, r;
   logic pready, pslverr, e;
   logic [7:0] pin_i, pin_o, pin_oe_n, pull_up_en, pull_dn_en;
   int fail_count = 0;
   int checks_done = 0;
   ppd_port dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .prdata, .pready, .pslverr, .alt_level, .pin_i, .pin_o,
      .pin_oe_n, .pull_up_en, .pull_dn_en);
   ppd_board board (.pclk, .pin_o, .pin_oe_n, .pull_up_en, .pull_dn_en,
      .ext_lvl, .ext_en, .pin_i);
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : test_done
   task automatic chk(input string nm, input logic [31:0] got, exp);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [17:0] ix,
         input logic [31:0] wd, input logic [3:0] st);
      int n;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= {ix, 2'h0};
      pwdata <= wd;
      pstrb <= st;
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'h1 && n < 9);
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (pready !== 1'h1)
      begin
         fail_count++;
         test_done;
      end
   endtask : apb
   task automatic wr(input logic [17:0] ix, input logic [31:0] d);
      apb(1'h1, ix, d, 4'hf);
   endtask : wr
   task automatic rd(input logic [17:0] ix);
      apb(1'h0, ix, 32'h0000_0000, 4'h0);
   endtask : rd
   task automatic settle;
      repeat (2) @(negedge pclk);
   endtask : settle
   task automatic t_reset;
      rd(`PPD_IDX_DIR);
      chk("dir", r, 32'h0000_0000);
      rd(`PPD_IDX_CTRL_LO);
      chk("ctrl", r, 32'h0000_0000);
      chk("oe_n", pin_oe_n, 8'hff);
      rd(18'h0_f230);
      chk("err", e, 1'h1);
   endtask : t_reset
   task automatic t_out;
      logic [7:0] x;
      wr(`PPD_IDX_DATA, 32'h0000_005a);
      rd(`PPD_IDX_DATA);
      chk("latch", r, 32'h0000_005a);
      for (int s = 0; s < 4; s++)
      begin
         wr(`PPD_IDX_CTRL_LO, {16'h0000, {8{s[1]}}, {8{s[0]}}});
         x = s == 0 ? 8'hff : s == 1 ? 8'ha5 : s == 2 ? 8'h5a : 8'h00;
         settle;
         chk("oe_n", pin_oe_n, x);
         chk("pad", pin_i & ~x, 8'h5a & ~x);
         rd(`PPD_IDX_CTRL_LO);
         chk("ctrl", r, {16'h0000, {8{s[1]}}, {8{s[0]}}});
      end
   endtask : t_out
   task automatic t_in;
      wr(`PPD_IDX_DIR, 32'h0000_00ff);
      for (int s = 0; s < 4; s++)
      begin
         wr(`PPD_IDX_CTRL_LO, {16'h0000, {8{s[1]}}, {8{s[0]}}});
         settle;
         chk("up", pull_up_en, s == 2 ? 8'hff : 8'h00);
         chk("dn", pull_dn_en, s == 1 ? 8'hff : 8'h00);
      end
      @(posedge pclk);
      ext_en <= 8'hff;
      ext_lvl <= 8'h3c;
      rd(`PPD_IDX_DATA);
      chk("in", r, 32'h0000_003c);
      ext_en <= 8'h00;
      wr(`PPD_IDX_DIR, 32'h0000_0000);
   endtask : t_in
   task automatic t_bytes;
      wr(`PPD_IDX_CTRL_HI, 32'h0000_00a5);
      apb(1'h1, `PPD_IDX_CTRL_LO, 32'h0000_3c3c, 4'h1);
      rd(`PPD_IDX_CTRL_LO);
      chk("word", r, 32'h0000_a53c);
      rd(`PPD_IDX_CTRL_HI);
      chk("hibyte", r, 32'h0000_00a5);
   endtask : t_bytes
   task automatic t_alt;
      alt_level <= 8'ha0;
      wr(`PPD_IDX_MODE_LO, 32'h0000_00f0);
      wr(`PPD_IDX_CTRL_LO, 32'h0000_0000);
      settle;
      chk("alt0", pin_oe_n, 8'haf);
      wr(`PPD_IDX_CTRL_LO, 32'h0000_00ff);
      settle;
      chk("alt1", pin_oe_n, 8'h05);
      chk("altpad", pin_i[7:4], 4'ha);
      wr(`PPD_IDX_MODE_LO, 32'h0000_0000);
      wr(`PPD_IDX_CTRL_LO, 32'h0000_0000);
      settle;
      chk("idle", pin_oe_n, 8'hff);
   endtask : t_alt
   initial
   begin
      forever #2.5 pclk = ~pclk;
   end
   initial
   begin
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      t_reset;
      t_out;
      t_in;
      t_bytes;
      t_alt;
      test_done;
   end
endmodule : tb_top
`default_nettype wire
